/* acc_adc_ctrl.sv */
// Conversion control: special function registers, prescaler, sequencer.
// Assumes an 8-bit SFR bus on ref_clk_i and an analog core outside.
// Behaviour
// - Start bit write begins single conversion
// - Hardware clears start bit when done
// - End flag set on result; software clears
// - Interrupt while flag and enable set
// - Channel select picks input binary
// - Full scale 3ff, ground 000
// - Prescaler divides 4xPRS, 2xPRS; PRS 0 gives 128, 64
// - Enable bit; clear means standby
// - Pseudo-idle halts processor during conversion
// - Routing bits hand pins to converter
// - Pseudo-idle: only end interrupt wakes
// - Start on unrouted channel does nothing
// - Conversion takes eleven converter clocks
`timescale 1ns/100ps
`include "acc_params.svh"
module acc_adc_ctrl #(
    parameter int DIV_W = 12
) (
    input  wire logic        ref_clk_i,        // 200 MHz clock
    input  wire logic        arst_n_i,         // Async reset, active low
    input  wire logic        double_speed_i,   // Double speed mode level
    input  wire logic [7:0]  sfr_addr_i,       // SFR address
    input  wire logic        sfr_wr_i,         // SFR write strobe
    input  wire logic        sfr_rd_i,         // SFR read strobe
    input  wire logic [7:0]  sfr_wdata_i,      // SFR write data
    input  wire logic        irq_enable_i,     // converter_irq_enable bit
    input  wire logic        other_irq_i,      // Any other pending interrupt
    input  wire logic        cmp_hi_i,         // Comparator: input above trial
    input  wire logic        above_ref_i,      // Input at or above reference
    input  wire logic        below_gnd_i,      // Input at or below ground
    output logic [7:0]       sfr_rdata_o,      // SFR read data
    output logic             sfr_hit_o,        // Address is ours
    output logic [7:0]       pin_route_o,      // Pins routed to converter
    output logic [2:0]       mux_sel_o,        // Analog mux select
    output logic             analog_on_o,      // Converter powered
    output logic             sample_o,         // Sample-and-hold active
    output logic [9:0]       trial_o,          // Trial code to DAC
    output logic             irq_o,            // Interrupt request
    output logic             cpu_halt_o,       // Processor idled
    output logic             other_irq_hold_o  // Mask other interrupts
);
    acc_pkg::acc_state_t state_q;
    logic [`ACC_PRS_W-1:0]  prs_q;
    logic [2:0]             ch_q;
    logic                   en_q;
    logic                   pseudo_idle_precision_q;
    logic                   eoc_q;
    logic                   busy_q;
    logic                   idle_conv_q;
    logic [9:0]             res_q;
    logic [9:0]             sar_q;
    logic [3:0]             step_q;
    logic [DIV_W-1:0]       div;
    logic                   tick;
    logic                   wr_ctl;
    logic                   start_req;
    logic                   done;
    logic                   sync1_q;
    logic                   spd1_q;
    logic                   sync2_q;
    logic                   cmp_q;
    logic                   aref1_q;
    logic                   aref_q;
    logic                   agnd1_q;
    logic                   agnd_q;

    // Comparator output crosses from the analog side
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1_q <= 1'b0;
            cmp_q   <= 1'b0;
        end else begin
            sync1_q <= cmp_hi_i;
            cmp_q   <= sync1_q;
        end
    end

    // Clamp detectors cross from the analog side
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            aref1_q <= 1'b0;
            aref_q  <= 1'b0;
            agnd1_q <= 1'b0;
            agnd_q  <= 1'b0;
        end else begin
            aref1_q <= above_ref_i;
            aref_q  <= aref1_q;
            agnd1_q <= below_gnd_i;
            agnd_q  <= agnd1_q;
        end
    end

    // Speed mode pin: two stages before the divisor reads it
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            spd1_q  <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            spd1_q  <= double_speed_i;
            sync2_q <= spd1_q;
        end
    end

    // Divisor selection
    // prescaler divisor
    always_comb begin
        if (prs_q == '0) begin
            div = sync2_q ? DIV_W'(`ACC_DIV_ZERO_X2) : DIV_W'(`ACC_DIV_ZERO_X1);
        end else if (sync2_q) begin
            div = DIV_W'({prs_q, 1'b0});
        end else begin
            div = DIV_W'({prs_q, 2'b00});
        end
    end

    acc_clk_div #(
        .W (DIV_W)
    ) u_div (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .run_i     (busy_q),
        .div_i     (div),
        .tick_o    (tick)
    );

    assign wr_ctl = sfr_wr_i && (sfr_addr_i == `ACC_OFS_CONTROL);
    // routed channel only; ignore while busy
    assign start_req = wr_ctl && sfr_wdata_i[`ACC_BIT_START] && !busy_q
                       && sfr_wdata_i[`ACC_BIT_ENABLE]
                       && pin_route_o[sfr_wdata_i[`ACC_FLD_CH_HI:`ACC_FLD_CH_LO]];
    assign done = (state_q == acc_pkg::ACC_DECIDE) && tick
                  && (step_q == `ACC_CONV_CLOCKS - 4'h1);

    // Prescaler register
    // prescale field
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prs_q <= '0;
        end else if (sfr_wr_i && (sfr_addr_i == `ACC_OFS_CLKDIV)) begin
            prs_q <= sfr_wdata_i[`ACC_PRS_W-1:0];
        end
    end

    // Pin routing register
    // routing bits
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_route_o <= `ACC_RST_BYTE;
        end else if (sfr_wr_i && (sfr_addr_i == `ACC_OFS_ROUTING)) begin
            pin_route_o <= sfr_wdata_i;
        end
    end

    // Control fields, frozen while a conversion runs
    // channel select, enable, busy freeze
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ch_q     <= '0;
            en_q     <= 1'b0;
            pseudo_idle_precision_q <= 1'b0;
        end else if (wr_ctl && !busy_q) begin
            ch_q     <= sfr_wdata_i[`ACC_FLD_CH_HI:`ACC_FLD_CH_LO];
            en_q     <= sfr_wdata_i[`ACC_BIT_ENABLE];
            pseudo_idle_precision_q <= sfr_wdata_i[`ACC_BIT_PSEUDO_IDLE_PRECISION];
        end
    end

    // End-of-conversion flag: set wins over software clear
    // sticky flag
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            eoc_q <= 1'b0;
        end else if (done) begin
            eoc_q <= 1'b1;
        end else if (wr_ctl && !sfr_wdata_i[`ACC_BIT_EOC]) begin
            eoc_q <= 1'b0;
        end
    end

    // Conversion sequencer: one sample clock then ten decisions
    // start, self-clear, eleven clocks
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q     <= acc_pkg::ACC_IDLE;
            busy_q      <= 1'b0;
            idle_conv_q <= 1'b0;
            step_q      <= '0;
            sar_q       <= '0;
        end else begin
            case (state_q)
                acc_pkg::ACC_IDLE: begin
                    if (start_req) begin
                        state_q     <= acc_pkg::ACC_SAMPLE;
                        busy_q      <= 1'b1;
                        idle_conv_q <= sfr_wdata_i[`ACC_BIT_PSEUDO_IDLE_PRECISION];
                        step_q      <= '0;
                        sar_q       <= `ACC_TRIAL_MSB;
                    end
                end
                acc_pkg::ACC_SAMPLE: begin
                    if (!en_q) begin
                        state_q <= acc_pkg::ACC_IDLE;
                        busy_q  <= 1'b0;
                        idle_conv_q <= 1'b0;
                    end else if (tick) begin
                        state_q <= acc_pkg::ACC_DECIDE;
                        step_q  <= `ACC_SAMPLE_CLOCKS;
                    end
                end
                acc_pkg::ACC_DECIDE: begin
                    if (!en_q) begin
                        state_q     <= acc_pkg::ACC_IDLE;
                        busy_q      <= 1'b0;
                        idle_conv_q <= 1'b0;
                    end else if (tick) begin
                        // Keep or drop trial bit, try next lower bit
                        sar_q  <= (cmp_q ? sar_q : (sar_q & ~(sar_q & -sar_q)))
                                  | ((sar_q & -sar_q) >> 1);
                        step_q <= step_q + 4'h1;
                        if (done) begin
                            state_q     <= acc_pkg::ACC_IDLE;
                            busy_q      <= 1'b0;
                            idle_conv_q <= 1'b0;
                        end
                    end
                end
                default: begin
                    state_q <= acc_pkg::ACC_IDLE;
                    busy_q  <= 1'b0;
                end
            endcase
        end
    end

    // Result capture in the same cycle as the flag
    // joint update, clamps, split result
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            res_q <= '0;
        end else if (done) begin
            if (aref_q) begin
                res_q <= `ACC_FULL_SCALE;
            end else if (agnd_q) begin
                res_q <= `ACC_ZERO_SCALE;
            end else begin
                res_q <= cmp_q ? sar_q : (sar_q & `ACC_LSB_CLEAR);
            end
        end
    end

    // Registered outputs toward the analog core and processor
    // interrupt, halt, wake only on end
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mux_sel_o        <= '0;
            analog_on_o      <= 1'b0;
            sample_o         <= 1'b0;
            trial_o          <= '0;
            irq_o            <= 1'b0;
            cpu_halt_o       <= 1'b0;
            other_irq_hold_o <= 1'b0;
        end else begin
            mux_sel_o        <= ch_q;
            analog_on_o      <= en_q;
            sample_o         <= (state_q == acc_pkg::ACC_SAMPLE);
            trial_o          <= sar_q;
            irq_o            <= (eoc_q || done) && irq_enable_i;
            cpu_halt_o       <= idle_conv_q && busy_q && !done;
            other_irq_hold_o <= idle_conv_q && busy_q && !done && other_irq_i;
        end
    end

    // Register read mux; reserved bits read as zero
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sfr_rdata_o <= `ACC_RST_BYTE;
            sfr_hit_o   <= 1'b0;
        end else if (sfr_rd_i) begin
            sfr_hit_o <= 1'b1;
            case (sfr_addr_i)
                `ACC_OFS_CLKDIV:   sfr_rdata_o <= {3'h0, prs_q};
                `ACC_OFS_CONTROL:  sfr_rdata_o <= {1'b0, pseudo_idle_precision_q, en_q, eoc_q,
                                                   busy_q, ch_q};
                `ACC_OFS_RES_LOW:  sfr_rdata_o <= {6'h00, res_q[1:0]};
                `ACC_OFS_RES_HIGH: sfr_rdata_o <= res_q[9:2];
                `ACC_OFS_ROUTING:  sfr_rdata_o <= pin_route_o;
                default: begin
                    sfr_rdata_o <= `ACC_RST_BYTE;
                    sfr_hit_o   <= 1'b0;
                end
            endcase
        end else begin
            sfr_hit_o <= 1'b0;
        end
    end
endmodule // acc_adc_ctrl

/* acc_params.svh */
// Constants for the conversion control block: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the block's design files.
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH
`define ACC_OFS_CLKDIV      8'hf2
`define ACC_OFS_CONTROL     8'hf3
`define ACC_OFS_RES_LOW     8'hf4
`define ACC_OFS_RES_HIGH    8'hf5
`define ACC_OFS_ROUTING     8'hf6
`define ACC_RST_BYTE        8'h00
`define ACC_BIT_START       3
`define ACC_BIT_EOC         4
`define ACC_BIT_ENABLE      5
`define ACC_BIT_PSEUDO_IDLE_PRECISION      6
`define ACC_FLD_CH_HI       2
`define ACC_FLD_CH_LO       0
`define ACC_PRS_W           5
`define ACC_DIV_ZERO_X2     12'h040
`define ACC_DIV_ZERO_X1     12'h080
`define ACC_CONV_CLOCKS     4'hb
`define ACC_SAMPLE_CLOCKS   4'h1
`define ACC_RES_W           10
`define ACC_FULL_SCALE      10'h3ff
`define ACC_TRIAL_MSB       10'h200
`define ACC_LSB_CLEAR       10'h3fe
`define ACC_ZERO_SCALE      10'h000
`endif

/* acc_pkg.sv */
// Types for the conversion control block.
// Assumes acc_params.svh is compiled alongside.
package acc_pkg;
    typedef enum logic [2:0] {
        ACC_IDLE   = 3'b001,
        ACC_SAMPLE = 3'b010,
        ACC_DECIDE = 3'b100
    } acc_state_t;
endpackage

/* acc_clk_div.sv */
// Converter clock divider producing one-cycle enable pulses.
// Assumes a single clock domain and a divisor of at least one.
`timescale 1ns/100ps
module acc_clk_div #(
    parameter int W = 12
) (
    input  wire logic         ref_clk_i,  // System clock
    input  wire logic         arst_n_i,   // Async reset, active low
    input  wire logic         run_i,      // Count while high
    input  wire logic [W-1:0] div_i,      // Divisor in cycles
    output logic              tick_o      // One-cycle converter tick
);
    logic [W-1:0] cnt_q;

    // Count up, pulse on wrap
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q  <= '0;
            tick_o <= 1'b0;
        end else if (!run_i) begin
            cnt_q  <= '0;
            tick_o <= 1'b0;
        end else if (cnt_q >= div_i - W'(1)) begin
            cnt_q  <= '0;
            tick_o <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + W'(1);
            tick_o <= 1'b0;
        end
    end
endmodule // acc_clk_div

/* acc_adc_ctrl_assertions.sv */
// Checker for the conversion control block, bound onto its top module.
// Assumes one clock domain and a prescale setting that is stable during conversions.
`timescale 1ns/100ps
module acc_adc_ctrl_checker (
    input  wire logic       ref_clk_i,       // Clock
    input  wire logic       arst_n_i,        // Reset, active low
    input  wire logic       double_speed_i,  // Speed mode
    input  wire logic [7:0] sfr_addr_i,      // Bus address
    input  wire logic       sfr_wr_i,        // Write strobe
    input  wire logic [7:0] sfr_wdata_i,     // Write data
    input  wire logic       irq_enable_i,    // Irq enable
    input  wire logic       other_irq_i,     // Other irq
    input  wire logic [7:0] pin_route_o,     // Routed pins
    input  wire logic [2:0] mux_sel_o,       // Mux select
    input  wire logic       analog_on_o,     // Powered
    input  wire logic       sample_o,        // Sampling
    input  wire logic       irq_o,           // Irq request
    input  wire logic       cpu_halt_o,      // Processor idled
    input  wire logic       other_irq_hold_o // Deferral
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    logic [4:0]  prs_q;
    logic [15:0] cnt_q;
    int          dv;
    // Mirror of the prescale field
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
        if (!arst_n_i) prs_q <= 5'h00;
        else if (sfr_wr_i && sfr_addr_i == 8'hf2) prs_q <= sfr_wdata_i[4:0];
    // Length of the current halted span
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
        if (!arst_n_i) cnt_q <= 16'h0000;
        else cnt_q <= cpu_halt_o ? cnt_q + 16'h0001 : 16'h0000;
    // Converter clock divisor in system cycles
    always_comb dv = prs_q == 0 ? (double_speed_i ? 64 : 128) : (double_speed_i ? 2 : 4) * prs_q;
    standby_off_a:
        assert property (!analog_on_o |-> !sample_o && !cpu_halt_o) else $error("busy in standby");
    start_routed_a:
        assert property ($rose(sample_o) |-> pin_route_o[mux_sel_o] && analog_on_o)
        else $error("conversion on unrouted pin");
    mux_steady_a:
        assert property (cpu_halt_o && $past(cpu_halt_o) |-> $stable(mux_sel_o))
        else $error("channel changed mid conversion");
    halt_start_a:
        assert property ($rose(cpu_halt_o) |-> $rose(sample_o)) else $error("halt without start");
    irq_gate_a:
        assert property (!irq_enable_i |=> !irq_o) else $error("irq while disabled");
    defer_other_a:
        assert property (other_irq_hold_o |-> $past(other_irq_i) && cpu_halt_o)
        else $error("deferral outside halted conversion");
    route_hold_a:
        assert property (!$past(sfr_wr_i) |-> $stable(pin_route_o)) else $error("routing drifted");
    conv_len_a:
        assert property ($fell(cpu_halt_o) |-> cnt_q >= 10 * dv && cnt_q <= 11 * dv + 8)
        else $error("conversion length wrong");
    wake_irq_a:
        assert property ($fell(cpu_halt_o) |-> ##[1:2] irq_o == irq_enable_i)
        else $error("no wake interrupt after halted conversion");
    cover property ($rose(cpu_halt_o));
    cover property ($rose(irq_o));
    cover property (other_irq_hold_o);
endmodule // acc_adc_ctrl_checker

bind acc_adc_ctrl acc_adc_ctrl_checker acc_chk_inst (
    .ref_clk_i, .arst_n_i, .double_speed_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i,
    .irq_enable_i, .other_irq_i, .pin_route_o, .mux_sel_o, .analog_on_o, .sample_o,
    .irq_o, .cpu_halt_o, .other_irq_hold_o);

/* acc_analog_model.sv */
// Analog side: input levels, sample-and-hold, comparator and clamp detectors.
// Assumes levels in codes; the input sits mid-code, so code equal to trial is above it.
`timescale 1ns/100ps
module acc_analog_model (
    input  wire logic               ref_clk_i,   // System clock
    input  wire logic               sample_i,    // Track while high
    input  wire logic [9:0]         trial_i,     // Trial code
    input  wire logic [2:0]         mux_sel_i,   // Selected input
    input  wire logic signed [11:0] lvl_i [8],   // Input levels
    output logic                    cmp_hi_o,    // Held above trial
    output logic                    above_ref_o, // At or above reference
    output logic                    below_gnd_o  // At or below ground
);
    logic signed [11:0] held_q = 12'sh000;
    // Track the selected input while sampling, hold afterwards
    always @(posedge ref_clk_i) if (sample_i) held_q <= lvl_i[mux_sel_i];
    assign cmp_hi_o = held_q >= $signed({2'b00, trial_i});
    assign above_ref_o = held_q >= 12'sh3ff;
    assign below_gnd_o = held_q <= 12'sh000;
endmodule // acc_analog_model

/* acc_adc_ctrl_test.sv */
// Testbench for the conversion control block acting as the processor.
// Assumes the analog model on the far side and reads answered one cycle later.
`timescale 1ns/100ps
`define CHK(a,b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
    $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module acc_adc_ctrl_test;
    logic ref_clk_i = 0, arst_n_i = 0, double_speed_i = 0, sfr_wr_i = 0, sfr_rd_i = 0;
    logic irq_enable_i = 0, other_irq_i = 0, rd_seen = 0;
    logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o, pin_route_o;
    logic cmp_hi_i, above_ref_i, below_gnd_i, sfr_hit_o, analog_on_o, sample_o, irq_o;
    logic cpu_halt_o, other_irq_hold_o;
    logic [2:0] mux_sel_o;
    logic [9:0] trial_o, e;
    logic [9:0] expq[$];
    logic signed [11:0] lvl [8];
    int num_errors = 0, tests_run = 0, seed = 32'h9893ce22;
    acc_adc_ctrl acc_adc_ctrl_inst (.ref_clk_i, .arst_n_i, .double_speed_i, .sfr_addr_i,
        .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .irq_enable_i, .other_irq_i, .cmp_hi_i,
        .above_ref_i, .below_gnd_i, .sfr_rdata_o, .sfr_hit_o, .pin_route_o, .mux_sel_o,
        .analog_on_o, .sample_o, .trial_o, .irq_o, .cpu_halt_o, .other_irq_hold_o);
    acc_analog_model acc_analog_model_inst (.ref_clk_i, .sample_i(sample_o), .trial_i(trial_o),
        .mux_sel_i(mux_sel_o), .lvl_i(lvl), .cmp_hi_o(cmp_hi_i), .above_ref_o(above_ref_i),
        .below_gnd_o(below_gnd_i));
    always #2.5 ref_clk_i = ~ref_clk_i;
    // Bus write: one cycle strobe from a falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk_i); sfr_addr_i = a; sfr_wdata_i = d; sfr_wr_i = 1;
        @(negedge ref_clk_i); sfr_wr_i = 0;
    endtask
    // Bus read; note is {care, hit, data}
    task automatic rd(input logic [7:0] a, input logic [9:0] n, output logic [7:0] d);
        @(negedge ref_clk_i); sfr_addr_i = a; sfr_rd_i = 1; expq.push_back(n);
        @(negedge ref_clk_i); sfr_rd_i = 0; d = sfr_rdata_o;
    endtask
    task automatic ck(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] x;
        rd(a, {2'b11, d}, x);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Read monitor: oldest note against the answer
    always @(posedge ref_clk_i) rd_seen <= sfr_rd_i;
    always @(negedge ref_clk_i) if (rd_seen) begin
        e = expq.pop_front();
        `CHK(sfr_hit_o, e[8])
        if (e[9]) `CHK(sfr_rdata_o, e[7:0])
    end
    // Main sequence
    initial begin
        logic [7:0] x, ps;
        logic [9:0] r;
        int n;
        for (int c = 0; c < 8; c++) lvl[c] = {2'b00, 10'($random(seed))};
        lvl[0] = 12'sh7d0;
        lvl[2] = -12'sh003;
        repeat (10) @(negedge ref_clk_i);
        arst_n_i = 1;
        for (int a = 242; a < 247; a++) ck(8'(a), 8'h00);
        rd(8'hf1, 10'h000, x);
        $display("test reset values done");
        wr(8'hf6, 8'h7f);
        `CHK(pin_route_o, 8'h7f)
        wr(8'hf3, 8'h09);
        ck(8'hf3, 8'h01);
        `CHK(analog_on_o, 1'b0)
        wr(8'hf3, 8'h20);
        repeat (800) @(negedge ref_clk_i);
        wr(8'hf3, 8'h2f);
        ck(8'hf3, 8'h27);
        wr(8'hf6, 8'hff);
        $display("test standby and routing done");
        for (int c = 0; c < 8; c++) begin
            ps = c[2] ? 8'h40 : 8'h00;
            double_speed_i = c[0];
            irq_enable_i = $random(seed);
            other_irq_i = $random(seed);
            // divisors scaled down with the system clock
            wr(8'hf2, {6'b0, c[1], 1'b0});
            r = lvl[c] > 1023 ? 10'h3ff : lvl[c] < 0 ? 10'h000 : lvl[c][9:0];
            wr(8'hf3, 8'h28 | ps | 8'(c));
            wr(8'hf3, 8'h28 | 8'(c ^ 1));
            `CHK(mux_sel_o, 3'(c))
            `CHK(cpu_halt_o, c[2])
            `CHK(other_irq_hold_o, c[2] & other_irq_i)
            n = 0;
            do begin rd(8'hf3, 10'h100, x); n++; end while (x[3] !== 1'b0 && n < 2000);
            if (n >= 2000) begin
                num_errors++;
                end_sim();
            end
            ck(8'hf3, 8'h30 | ps | 8'(c));
            ck(8'hf5, r[9:2]);
            ck(8'hf4, {6'b0, r[1:0]});
            `CHK(irq_o, irq_enable_i)
            wr(8'hf3, 8'h20 | ps | 8'(c));
            ck(8'hf3, 8'h20 | ps | 8'(c));
            `CHK(irq_o, 1'b0)
            $display("test conversion %0d done", c);
        end
        end_sim();
    end
endmodule // acc_adc_ctrl_test
